// File: core/cs_decoder_defs.svh
`ifndef CS_DECODER_DEFS_SVH
`define CS_DECODER_DEFS_SVH
`define REG_IDX_W 8
`define IDX_PIN2_CMP_LO 8'hac
`define IDX_PIN2_CMP_HI 8'had
`define IDX_PIN3_CMP_LO 8'hb4
`define IDX_PIN3_CMP_HI 8'hb5
`define IDX_PINS01_CFG 8'hc2
`define IDX_PINS23_CFG 8'hc3
`define IDX_PIN0_CMP_LO 8'hd8
`define IDX_PIN0_CMP_HI 8'hd9
`define IDX_PIN1_CMP_LO 8'hda
`define IDX_PIN1_CMP_HI 8'hdb
`define IDX_PORT_LATCH 8'hdc
`define IDX_PIN_STATE 8'hdd
`define FUN_HI_LSB 6
`define LEN_HI_LSB 4
`define FUN_LO_LSB 2
`define LEN_LO_LSB 0
`define FUNC_GPIO 2'h0
`define FUNC_RD 2'h1
`define FUNC_WR 2'h2
`define FUNC_RW 2'h3
`define LEN_16 2'h0
`define LEN_15 2'h1
`define LEN_14 2'h2
`define LEN_8 2'h3
`define MASK_16 16'hffff
`define MASK_15 16'hfffe
`define MASK_14 16'hfffc
`define MASK_8 16'hff00
`define CFG_RESET 8'h00
`define CMP_RESET 8'h00
`define LATCH_RESET 4'hf
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0
`endif

// File: core/cs_decoder_pkg.sv
`default_nettype none
`include "cs_decoder_defs.svh"
package cs_decoder_pkg;
  typedef enum logic [1:0] {
    FN_GPIO = `FUNC_GPIO,
    FN_RD = `FUNC_RD,
    FN_WR = `FUNC_WR,
    FN_RW = `FUNC_RW
  } pin_func_t;
  typedef enum logic [1:0] {
    LN_16 = `LEN_16,
    LN_15 = `LEN_15,
    LN_14 = `LEN_14,
    LN_8 = `LEN_8
  } cmp_len_t;
endpackage : cs_decoder_pkg
`default_nettype wire

// File: core/cs_pin_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cs_pin_if;
  import cs_decoder_pkg::*;
  pin_func_t func;
  cmp_len_t len;
  logic [15:0] cmp_word;
  logic [15:0] bus_addr;
  logic bus_rd;
  logic bus_wr;
  logic hit;
  modport cfg (output func, len, cmp_word, bus_addr, bus_rd, bus_wr,
    input hit);
  modport match (input func, len, cmp_word, bus_addr, bus_rd, bus_wr,
    output hit);
endinterface : cs_pin_if
`default_nettype wire

// File: core/cs_addr_match.sv
`timescale 1ns/1ps
`default_nettype none
`include "cs_decoder_defs.svh"
module cs_addr_match
  import cs_decoder_pkg::*;
(
  cs_pin_if.match pin
);
  logic [15:0] mask;
  logic addr_eq;
  logic access_ok;

  always_comb
  begin
    unique case (pin.len)
      LN_16: mask = `MASK_16; // RULE_05
      LN_15: mask = `MASK_15; // RULE_06
      LN_14: mask = `MASK_14; // RULE_07
      LN_8: mask = `MASK_8; // RULE_08
    endcase
  end

  assign addr_eq = ((pin.bus_addr ^ pin.cmp_word) & mask) == 16'h0000;

  always_comb
  begin
    unique case (pin.func)
      FN_GPIO: access_ok = 1'b0; // RULE_01
      FN_RD: access_ok = pin.bus_rd; // RULE_02
      FN_WR: access_ok = pin.bus_wr; // RULE_03
      FN_RW: access_ok = pin.bus_rd | pin.bus_wr; // RULE_04
    endcase
  end

  assign pin.hit = addr_eq & access_ok;
endmodule : cs_addr_match
`default_nettype wire

// File: core/port4_chip_select_decoder.sv
// Functional notes
// [RULE_01] function 00: pin is a plain port bit like port 1
// [RULE_02] function 01: read strobe, asserted on in-range reads only
// [RULE_03] function 10: write strobe, asserted on in-range writes only
// [RULE_04] function 11: strobe asserted on in-range reads and writes
// [RULE_05] length 00: all 16 address bits compared with high:low bytes
// [RULE_06] length 01: upper 15 bits compared, address bit 0 ignored
// [RULE_07] length 10: upper 14 bits compared, two low bits ignored
// [RULE_08] length 11: only high byte compared, low bytes ignored
// [RULE_09] config b: pin 3 function 7:6, length 5:4, pin 2 function 3:2
// [RULE_10] config b: pin 2 length in bits 1:0, same encodings
// [RULE_11] config a: pin 1 function 7:6, length 5:4
// [RULE_12] config a: pin 0 function 3:2, length 1:0
// [RULE_13] each pin has own low/high compare bytes; pin 3 at b4h/b5h
// [RULE_14] strobe mode: pin low only on qualifying matched access, else high
// [RULE_15] after reset all function fields zero, pins are plain port bits
`timescale 1ns/1ps
`default_nettype none
`include "cs_decoder_defs.svh"
module port4_chip_select_decoder
  import cs_decoder_pkg::*;
#(
  parameter int PINS = 4
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] ext_addr,
  input wire logic ext_rd_n,
  input wire logic ext_wr_n,
  input wire logic [PINS-1:0] strobe_pin_in,
  output logic [PINS-1:0] strobe_pin_out,
  output logic [PINS-1:0] strobe_pin_oe
);
  logic [7:0] pins01_cs_config_q;
  logic [7:0] pins23_cs_config_q;
  logic [7:0] cmp_lo_q [PINS];
  logic [7:0] cmp_hi_q [PINS];
  logic [PINS-1:0] port_latch_q;
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;
  logic wr_pend_q;
  logic [`REG_IDX_W-1:0] wr_idx_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [PINS-1:0] pin_out_q;
  logic [PINS-1:0] pin_oe_q;

  logic [`REG_IDX_W-1:0] req_idx;
  logic req_ok;
  logic req_rd;
  logic req_wr;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  pin_func_t fun_w [PINS];
  cmp_len_t len_w [PINS];
  wire logic [PINS-1:0] hit_w;

  assign req_idx = haddr[`REG_IDX_W+1:2];
  assign req_ok = hsel & hready & htrans[1] & (haddr[31:`REG_IDX_W+2] ==
    '0) & (haddr[1:0] == 2'h0);
  assign req_rd = req_ok & ~hwrite;
  assign req_wr = req_ok & hwrite & (hsize == `HSIZE_WORD);
  assign wbyte = hwdata[7:0];

  function automatic logic writable(input logic [`REG_IDX_W-1:0] idx);
    unique case (idx)
      `IDX_PINS01_CFG, `IDX_PINS23_CFG, `IDX_PORT_LATCH,
      `IDX_PIN0_CMP_LO, `IDX_PIN0_CMP_HI, `IDX_PIN1_CMP_LO,
      `IDX_PIN1_CMP_HI, `IDX_PIN2_CMP_LO, `IDX_PIN2_CMP_HI,
      `IDX_PIN3_CMP_LO, `IDX_PIN3_CMP_HI: writable = 1'b1;
      default: writable = 1'b0;
    endcase
  endfunction : writable

  // field split of the two configuration bytes
  always_comb
  begin
    fun_w[0] = pin_func_t'(pins01_cs_config_q[`FUN_LO_LSB +: 2]); // RULE_12
    len_w[0] = cmp_len_t'(pins01_cs_config_q[`LEN_LO_LSB +: 2]); // RULE_12
    fun_w[1] = pin_func_t'(pins01_cs_config_q[`FUN_HI_LSB +: 2]); // RULE_11
    len_w[1] = cmp_len_t'(pins01_cs_config_q[`LEN_HI_LSB +: 2]); // RULE_11
    fun_w[2] = pin_func_t'(pins23_cs_config_q[`FUN_LO_LSB +: 2]); // RULE_09
    len_w[2] = cmp_len_t'(pins23_cs_config_q[`LEN_LO_LSB +: 2]); // RULE_10
    fun_w[3] = pin_func_t'(pins23_cs_config_q[`FUN_HI_LSB +: 2]); // RULE_09
    len_w[3] = cmp_len_t'(pins23_cs_config_q[`LEN_HI_LSB +: 2]); // RULE_09
  end

  // read mux; a write still in its data phase is forwarded
  always_comb
  begin
    rd_byte = 8'h00;
    if (wr_pend_q && wr_idx_q == req_idx && writable(req_idx))
    begin
      rd_byte = wbyte;
      if (req_idx == `IDX_PORT_LATCH)
        rd_byte = {{(8-PINS){1'b0}}, wbyte[PINS-1:0]};
    end
    else
    begin
      unique case (req_idx)
        `IDX_PINS01_CFG: rd_byte = pins01_cs_config_q;
        `IDX_PINS23_CFG: rd_byte = pins23_cs_config_q;
        `IDX_PIN0_CMP_LO: rd_byte = cmp_lo_q[0];
        `IDX_PIN0_CMP_HI: rd_byte = cmp_hi_q[0];
        `IDX_PIN1_CMP_LO: rd_byte = cmp_lo_q[1];
        `IDX_PIN1_CMP_HI: rd_byte = cmp_hi_q[1];
        `IDX_PIN2_CMP_LO: rd_byte = cmp_lo_q[2];
        `IDX_PIN2_CMP_HI: rd_byte = cmp_hi_q[2];
        `IDX_PIN3_CMP_LO: rd_byte = cmp_lo_q[3];
        `IDX_PIN3_CMP_HI: rd_byte = cmp_hi_q[3];
        `IDX_PORT_LATCH: rd_byte = {{(8-PINS){1'b0}}, port_latch_q};
        `IDX_PIN_STATE: rd_byte = {{(8-PINS){1'b0}}, pin_sync_q};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // bus slave: zero wait states, always okay
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b0;
      hresp_q <= `HRESP_OKAY;
    end
    else
    begin
      hreadyout_q <= 1'b1;
      hresp_q <= `HRESP_OKAY;
      if (hready)
      begin
        wr_pend_q <= req_wr;
        wr_idx_q <= req_idx;
      end
      if (req_rd)
      begin
        hrdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pins01_cs_config_q <= `CFG_RESET; // RULE_15
      pins23_cs_config_q <= `CFG_RESET; // RULE_15
      port_latch_q <= `LATCH_RESET;
    end
    else if (wr_pend_q)
    begin
      if (wr_idx_q == `IDX_PINS01_CFG)
      begin
        pins01_cs_config_q <= wbyte; // RULE_11
      end
      if (wr_idx_q == `IDX_PINS23_CFG)
      begin
        pins23_cs_config_q <= wbyte; // RULE_09
      end
      if (wr_idx_q == `IDX_PORT_LATCH)
      begin
        port_latch_q <= wbyte[PINS-1:0];
      end
    end
  end

  // per-pin compare bytes
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < PINS; i++)
      begin
        cmp_lo_q[i] <= `CMP_RESET;
        cmp_hi_q[i] <= `CMP_RESET;
      end
    end
    else if (wr_pend_q)
    begin
      unique case (wr_idx_q)
        `IDX_PIN0_CMP_LO: cmp_lo_q[0] <= wbyte; // RULE_13
        `IDX_PIN0_CMP_HI: cmp_hi_q[0] <= wbyte; // RULE_13
        `IDX_PIN1_CMP_LO: cmp_lo_q[1] <= wbyte; // RULE_13
        `IDX_PIN1_CMP_HI: cmp_hi_q[1] <= wbyte; // RULE_13
        `IDX_PIN2_CMP_LO: cmp_lo_q[2] <= wbyte; // RULE_13
        `IDX_PIN2_CMP_HI: cmp_hi_q[2] <= wbyte; // RULE_13
        `IDX_PIN3_CMP_LO: cmp_lo_q[3] <= wbyte; // RULE_13
        `IDX_PIN3_CMP_HI: cmp_hi_q[3] <= wbyte; // RULE_13
        default: ;
      endcase
    end
  end

  // pin readback passes two flip-flops
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= strobe_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < PINS; g++)
    begin : g_pin
      cs_pin_if pin_if ();
      assign pin_if.func = fun_w[g];
      assign pin_if.len = len_w[g];
      assign pin_if.cmp_word = {cmp_hi_q[g], cmp_lo_q[g]}; // RULE_05
      assign pin_if.bus_addr = ext_addr;
      assign pin_if.bus_rd = ~ext_rd_n;
      assign pin_if.bus_wr = ~ext_wr_n;
      assign hit_w[g] = pin_if.hit;
      cs_addr_match u_match (
        .pin(pin_if)
      );
    end
  endgenerate

  // pin drive: strobe modes push-pull, port mode pulls low from latch
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
    end
    else
    begin
      for (int i = 0; i < PINS; i++)
      begin
        if (fun_w[i] == FN_GPIO)
        begin
          pin_out_q[i] <= 1'b0; // RULE_01
          pin_oe_q[i] <= ~port_latch_q[i]; // RULE_01
        end
        else
        begin
          pin_out_q[i] <= ~hit_w[i]; // RULE_14
          pin_oe_q[i] <= 1'b1; // RULE_14
        end
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign strobe_pin_out = pin_out_q;
  assign strobe_pin_oe = pin_oe_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_wr_cfg23;
    hsel && hready && htrans[1] && hwrite && hsize == `HSIZE_WORD &&
      haddr == {22'h0, `IDX_PINS23_CFG, 2'h0} ##1 hready;
  endsequence
  sequence s_wr_cfg01;
    hsel && hready && htrans[1] && hwrite && hsize == `HSIZE_WORD &&
      haddr == {22'h0, `IDX_PINS01_CFG, 2'h0} ##1 hready;
  endsequence
  sequence s_wr_pin3_lo;
    hsel && hready && htrans[1] && hwrite && hsize == `HSIZE_WORD &&
      haddr == {22'h0, `IDX_PIN3_CMP_LO, 2'h0} ##1 hready;
  endsequence

  a_cfg23_fields: assert property ( // RULE_09
    s_wr_cfg23 |=> fun_w[3] == $past(hwdata[7:6], 1) &&
      len_w[3] == $past(hwdata[5:4], 1) &&
      fun_w[2] == $past(hwdata[3:2], 1))
    else $error("config b fields not taken from written byte");

  a_cfg23_low_len: assert property ( // RULE_10
    s_wr_cfg23 |=> len_w[2] == $past(hwdata[1:0], 1))
    else $error("pin 2 length not in config b bits 1:0");

  a_cfg01_fields: assert property ( // RULE_11
    s_wr_cfg01 |=> fun_w[1] == $past(hwdata[7:6], 1) &&
      len_w[1] == $past(hwdata[5:4], 1))
    else $error("pin 1 fields not in config a 7:4");

  a_cfg01_low: assert property ( // RULE_12
    s_wr_cfg01 |=> fun_w[0] == $past(hwdata[3:2], 1) &&
      len_w[0] == $past(hwdata[1:0], 1))
    else $error("pin 0 fields not in config a 3:0");

  a_pin3_cmp_lo: assert property ( // RULE_13
    s_wr_pin3_lo |=> cmp_lo_q[3] == $past(hwdata[7:0], 1))
    else $error("pin 3 low compare byte not written");

  a_reset_port_mode: assert property ( // RULE_15
    @(posedge clk) $fell(reset) |-> pins01_cs_config_q == `CFG_RESET &&
      pins23_cs_config_q == `CFG_RESET && strobe_pin_oe == '0)
    else $error("pins not in port mode after reset");

  a_strobe_idle_high: assert property ( // RULE_14
    fun_w[3] != FN_GPIO && ext_rd_n && ext_wr_n ##1
      fun_w[3] == $past(fun_w[3]) |-> strobe_pin_oe[3] && strobe_pin_out[3])
    else $error("strobe pin not driven high while idle");

  for (g = 0; g < PINS; g++)
  begin : g_chk
    a_port_mode_drive: assert property ( // RULE_01
      fun_w[g] == FN_GPIO |=> !strobe_pin_out[g] &&
        strobe_pin_oe[g] == !$past(port_latch_q[g]))
      else $error("port mode pin drive wrong");

    a_read_only_strobe: assert property ( // RULE_02
      fun_w[g] == FN_RD && ext_rd_n |=> strobe_pin_out[g])
      else $error("read strobe asserted without read");

    a_write_only_strobe: assert property ( // RULE_03
      fun_w[g] == FN_WR && ext_wr_n |=> strobe_pin_out[g])
      else $error("write strobe asserted without write");

    a_rw_strobe_write: assert property ( // RULE_04
      fun_w[g] == FN_RW && !ext_wr_n && len_w[g] == LN_16 &&
        ext_addr == {cmp_hi_q[g], cmp_lo_q[g]} |=> !strobe_pin_out[g])
      else $error("read/write strobe missed a write");

    a_full_match: assert property ( // RULE_05
      fun_w[g] == FN_RW && !ext_rd_n && len_w[g] == LN_16 &&
        ext_addr != {cmp_hi_q[g], cmp_lo_q[g]} |=> strobe_pin_out[g])
      else $error("16-bit compare hit on other address");

    a_len15_match: assert property ( // RULE_06
      fun_w[g] == FN_RD && !ext_rd_n && len_w[g] == LN_15 &&
        ext_addr[15:1] == {cmp_hi_q[g], cmp_lo_q[g][7:1]}
        |=> !strobe_pin_out[g])
      else $error("15-bit compare missed");

    a_len14_match: assert property ( // RULE_07
      fun_w[g] == FN_WR && !ext_wr_n && len_w[g] == LN_14 &&
        ext_addr[15:2] == {cmp_hi_q[g], cmp_lo_q[g][7:2]}
        |=> !strobe_pin_out[g])
      else $error("14-bit compare missed");

    a_len8_match: assert property ( // RULE_08
      fun_w[g] == FN_RW && !ext_rd_n && len_w[g] == LN_8 &&
        ext_addr[15:8] == cmp_hi_q[g] |=> !strobe_pin_out[g])
      else $error("8-bit compare missed");
  end
endmodule : port4_chip_select_decoder
`default_nettype wire

// File: test/cs_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module cs_periph_model
(
  input wire logic [3:0] strobe_pin_out,
  input wire logic [3:0] strobe_pin_oe,
  input wire logic [3:0] pull_low,
  output logic [3:0] pin_level
);
  // pull-up on each line, wired-and of device and peripheral drivers
  assign pin_level = ~((strobe_pin_oe & ~strobe_pin_out) | pull_low);
endmodule : cs_periph_model
`default_nettype wire

// File: test/port4_chip_select_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cs_decoder_defs.svh"
module port4_chip_select_decoder_tb;
  import cs_decoder_pkg::*;
  logic clk = 0;
  logic reset = 1;
  logic hsel = 0;
  logic hwrite = 0;
  logic [31:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] hwdata = 0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [15:0] ext_addr = 0;
  logic ext_rd_n = 1;
  logic ext_wr_n = 1;
  logic [3:0] pin_in, pin_out, pin_oe;
  logic [3:0] pull_low = 0;
  int fail_count = 0;
  int compares = 0;
  logic [32:0] rd_q[$];
  logic [7:0] stb_q[$];
  logic rd_pend = 0;
  logic stb_arm = 0;
  logic stb_arm_d = 0;
  logic [1:0] fn[4];
  logic [1:0] ln[4];
  logic [15:0] cw[4];
  logic [3:0] latch;
  logic [15:0] flips[7];
  logic [15:0] masks[4] = '{16'hffff, 16'hfffe, 16'hfffc, 16'hff00};
  logic [7:0] lo_idx[4] = '{`IDX_PIN0_CMP_LO, `IDX_PIN1_CMP_LO,
    `IDX_PIN2_CMP_LO, `IDX_PIN3_CMP_LO};
  logic [7:0] hi_idx[4] = '{`IDX_PIN0_CMP_HI, `IDX_PIN1_CMP_HI,
    `IDX_PIN2_CMP_HI, `IDX_PIN3_CMP_HI};

  always #2.5 clk = ~clk;

  port4_chip_select_decoder port4_chip_select_decoder_inst (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_addr(ext_addr), .ext_rd_n(ext_rd_n),
    .ext_wr_n(ext_wr_n), .strobe_pin_in(pin_in),
    .strobe_pin_out(pin_out), .strobe_pin_oe(pin_oe));

  cs_periph_model cs_periph_model_inst (
    .strobe_pin_out(pin_out), .strobe_pin_oe(pin_oe),
    .pull_low(pull_low), .pin_level(pin_in));

  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic check(input logic [32:0] got, exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic chk_rd(input logic [32:0] got);
    check(got, rd_q.pop_front(), "read data");
  endtask : chk_rd

  task automatic chk_stb(input logic [7:0] got);
    check({25'h0, got}, {25'h0, stb_q.pop_front()}, "strobe pins");
  endtask : chk_stb

  // data phase and strobe results are judged here, off the queues
  always @(posedge clk)
  begin
    if (rd_pend && hreadyout === 1'b1)
      chk_rd({hresp, hrdata});
    if (hreadyout === 1'b1)
      rd_pend <= hsel & htrans[1] & ~hwrite;
    if (stb_arm_d)
      chk_stb({pin_oe, pin_out});
    stb_arm_d <= stb_arm;
  end

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 50)
    begin
      fail_count++;
      end_sim();
    end
  endtask : wait_rdy

  task automatic ahb(input logic [7:0] idx, input logic wr,
    input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= `HSIZE_WORD;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'($urandom), wd};
    wait_rdy();
  endtask : ahb

  task automatic ahb_rd(input logic [7:0] idx, input logic [7:0] exp);
    rd_q.push_back({25'h0, exp});
    ahb(idx, 1'b0, 8'h0);
  endtask : ahb_rd

  function automatic logic [7:0] expect_pins(input logic [15:0] a,
    input logic rd, wr);
    logic [7:0] r;
    logic hit;
    for (int p = 0; p < 4; p++)
    begin
      hit = ((a ^ cw[p]) & masks[ln[p]]) == 16'h0;
      hit = hit && (fn[p][0] && rd || fn[p][1] && wr);
      r[p + 4] = fn[p] != 2'h0 || !latch[p];
      r[p] = fn[p] != 2'h0 && !hit;
    end
    return r;
  endfunction : expect_pins

  task automatic ext(input logic [15:0] a, input logic rd, wr);
    ext_addr <= a;
    ext_rd_n <= ~rd;
    ext_wr_n <= ~wr;
    stb_q.push_back(expect_pins(a, rd, wr));
    stb_arm <= 1'b1;
    @(posedge clk);
    stb_arm <= 1'b0;
    @(posedge clk);
  endtask : ext

  task automatic write_cfg();
    ahb(`IDX_PINS01_CFG, 1'b1, {fn[1], ln[1], fn[0], ln[0]});
    ahb(`IDX_PINS23_CFG, 1'b1, {fn[3], ln[3], fn[2], ln[2]});
  endtask : write_cfg

  initial
  begin
    void'($urandom(53630));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int p = 0; p < 4; p++)
    begin
      fn[p] = 2'h0;
      ln[p] = 2'h0;
      cw[p] = 16'h0;
      ahb_rd(lo_idx[p], 8'h0);
      ahb_rd(hi_idx[p], 8'h0);
    end
    latch = 4'hf;
    ahb_rd(`IDX_PINS01_CFG, 8'h0);
    ahb_rd(`IDX_PINS23_CFG, 8'h0);
    ahb_rd(`IDX_PIN_STATE, 8'h0f);
    ahb_rd(8'h00, 8'h0);
    ext(16'h0, 1'b1, 1'b0);
    $display("test reset values done");
    for (int p = 0; p < 4; p++)
    begin
      cw[p] = 16'($urandom);
      ahb(lo_idx[p], 1'b1, cw[p][7:0]);
      ahb(hi_idx[p], 1'b1, cw[p][15:8]);
      ahb_rd(lo_idx[p], cw[p][7:0]);
      ahb_rd(hi_idx[p], cw[p][15:8]);
    end
    ahb(8'h01, 1'b1, 8'h5a);
    ahb_rd(8'h01, 8'h0);
    ahb(`IDX_PIN_STATE, 1'b1, 8'h00);
    ahb_rd(`IDX_PIN_STATE, 8'h0f);
    $display("test compare registers done");
    flips = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h80, 16'h100, 16'h0};
    for (int k = 0; k < 16; k++)
    begin
      for (int p = 0; p < 4; p++)
      begin
        fn[p] = 2'(k + p);
        ln[p] = 2'((k >> 2) + p);
      end
      write_cfg();
      ahb_rd(`IDX_PINS01_CFG, {fn[1], ln[1], fn[0], ln[0]});
      ahb_rd(`IDX_PINS23_CFG, {fn[3], ln[3], fn[2], ln[2]});
      flips[6] = 16'($urandom);
      for (int q = 0; q < 4; q++)
        for (int j = 0; j < 7; j++)
          for (int op = 0; op < 3; op++)
            ext(cw[q] ^ flips[j], op == 0, op == 1);
    end
    $display("test strobe modes and lengths done");
    for (int p = 0; p < 4; p++)
      fn[p] = 2'h0;
    write_cfg();
    latch = 4'ha;
    ahb(`IDX_PORT_LATCH, 1'b1, 8'h0a);
    ahb_rd(`IDX_PORT_LATCH, 8'h0a);
    ext(cw[0], 1'b1, 1'b1);
    pull_low <= 4'h2;
    repeat (4) @(posedge clk);
    ahb_rd(`IDX_PIN_STATE, 8'h08);
    ext(16'h0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    $display("test port mode done");
    end_sim();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule : port4_chip_select_decoder_tb
`default_nettype wire
